// ---- hw/ssa_align.sv ----
// How it works
// - Sixteen independent source streams taken together
// - One 32-bit word per stream per word cycle
// - Everything on one core clock, fully pipelined
// - Two lanes pair into one word link
// - Lanes carry 8b10b coded symbols, errors flagged
// - Errored words discarded as zero, flagged, no correction
// - Sync release starts writes, no reads yet
// - After alignment count all enabled FIFOs read together
// - Alignment count covers at least two words
// - FIFOs absorb per-link latency differences after relock
// - Outputs retimed by registers to fixed latency
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Word FIFO with valid and ready on both sides
module ssa_fifo #(
    parameter int W = 32,
    parameter int D = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] PTR_RST = '0;
    localparam logic [AW:0] PTR_ONE = (AW+1)'(1);

    logic [W-1:0] mem [D];            // Word storage
    logic [AW:0] wr_ptr, next_wr_ptr; // Write pointer with wrap bit
    logic [AW:0] rd_ptr, next_rd_ptr; // Read pointer with wrap bit
    logic do_wr, do_rd;

    // Full when pointers differ only in the wrap bit
    assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) &&
                        (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid = (wr_ptr != rd_ptr);
    assign out_data = mem[rd_ptr[AW-1:0]];
    assign do_wr = in_valid && in_ready && !flush;
    assign do_rd = out_valid && out_ready && !flush;

    // Pointer next values; flush empties at once
    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (flush) begin
            next_wr_ptr = PTR_RST;
            next_rd_ptr = PTR_RST;
        end else begin
            if (do_wr) begin
                next_wr_ptr = wr_ptr + PTR_ONE;
            end
            if (do_rd) begin
                next_rd_ptr = rd_ptr + PTR_ONE;
            end
        end
    end

    // Pointer registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wr_ptr <= PTR_RST;
            rd_ptr <= PTR_RST;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Storage write
    always_ff @(posedge core_clk) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule

// ============================================================
// Receive and align front end for sixteen source links
module ssa_align (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic run_sync,
    input wire logic [ssa_pkg::NUM_STREAMS-1:0] stream_enable,
    input wire logic [ssa_pkg::NUM_STREAMS-1:0] link_clk,
    input wire ssa_pkg::ssa_link_t [ssa_pkg::NUM_STREAMS-1:0] link_in,
    output logic [ssa_pkg::NUM_STREAMS-1:0][ssa_pkg::WORD_W-1:0] out_word,
    output logic out_valid,
    output logic running,
    output logic [ssa_pkg::NUM_STREAMS-1:0] code_error,
    output logic [ssa_pkg::NUM_STREAMS-1:0] align_error
);
    import ssa_pkg::*;

    // ========================================================
    // Control inputs synchroniser
    logic sync_s1, sync_s2;                 // Run sync stages
    logic [NUM_STREAMS-1:0] en_s1, en_s2;   // Enable mask stages
    logic next_sync_s1, next_sync_s2;
    logic [NUM_STREAMS-1:0] next_en_s1, next_en_s2;

    // Two flip-flops before any logic sees the pins
    always_comb begin
        next_sync_s1 = run_sync;
        next_sync_s2 = sync_s1;
        next_en_s1 = stream_enable;
        next_en_s2 = en_s1;
    end

    // Synchroniser registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync_s1 <= 1'b1;
            sync_s2 <= 1'b1;
            en_s1 <= FLAGS_RST;
            en_s2 <= FLAGS_RST;
        end else begin
            sync_s1 <= next_sync_s1;
            sync_s2 <= next_sync_s2;
            en_s1 <= next_en_s1;
            en_s2 <= next_en_s2;
        end
    end

    // ========================================================
    // Alignment state machine
    ssa_state_t state, next_state;          // Run phase
    logic [ALIGN_CNT_W-1:0] cnt, next_cnt;  // Cycles since release
    logic [NUM_STREAMS-1:0] link_edge;      // Word strobe per link
    logic read_tick;                        // Common read moment
    logic flush;                            // Empties every FIFO

    // Reads paced by link 0, all sources share one clock
    assign read_tick = (state == SSA_RUN) && link_edge[0];
    assign flush = (state == SSA_FLUSH);

    // Phase sequencing; sync high always returns to flush
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        if (sync_s2) begin
            next_state = SSA_FLUSH;
            next_cnt = ALIGN_CNT_RST;
        end else begin
            unique case (state)
                // Release: start filling, no reads
                SSA_FLUSH: begin
                    next_state = SSA_FILL;
                    next_cnt = ALIGN_CNT_RST;
                end
                // Wait the fixed alignment count
                SSA_FILL: begin
                    if (cnt == ALIGN_LAST) begin
                        next_state = SSA_RUN;
                    end else begin
                        next_cnt = cnt + 7'h01;
                    end
                end
                // Keep reading until sync comes back
                SSA_RUN: begin
                    next_state = SSA_RUN;
                end
                // Illegal code falls back to flush
                default: begin
                    next_state = SSA_FLUSH;
                    next_cnt = ALIGN_CNT_RST;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= SSA_FLUSH;
            cnt <= ALIGN_CNT_RST;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // ========================================================
    // Output strobe register
    logic next_out_valid, next_running;

    // Valid marks each cycle fresh words are presented
    always_comb begin
        next_out_valid = read_tick;
        next_running = (state == SSA_RUN);
    end

    // Strobe registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            out_valid <= 1'b0;
            running <= 1'b0;
        end else begin
            out_valid <= next_out_valid;
            running <= next_running;
        end
    end

    // ========================================================
    // Per stream receive, buffer and readout
    for (genvar i = 0; i < NUM_STREAMS; i++) begin : g_stream
        logic [2:0] clk_pipe, next_clk_pipe; // Link clock stages
        ssa_link_t d_s1, d_s2;               // Lane data stages
        ssa_link_t next_d_s1, next_d_s2;
        logic wr_valid, wr_ready;            // FIFO fill side
        logic [WORD_W-1:0] wr_data;
        logic rd_valid, rd_ready;            // FIFO drain side
        logic [WORD_W-1:0] rd_data;
        logic lane_err;                      // Either lane errored
        logic [WORD_W-1:0] next_word;
        logic next_code_err, next_align_err;

        // Sample link clock through three stages and lanes through two
        always_comb begin
            next_clk_pipe = {clk_pipe[1:0], link_clk[i]};
            next_d_s1 = link_in[i];
            next_d_s2 = d_s1;
        end

        // Link sampling registers
        always_ff @(posedge core_clk) begin
            if (reset) begin
                clk_pipe <= PIPE_RST;
                d_s1 <= LINK_RST;
                d_s2 <= LINK_RST;
            end else begin
                clk_pipe <= next_clk_pipe;
                d_s1 <= next_d_s1;
                d_s2 <= next_d_s2;
            end
        end

        // Rising edge seen past the first stage only
        assign link_edge[i] = clk_pipe[1] && !clk_pipe[2];
        assign lane_err = d_s2.hi.code_err || d_s2.lo.code_err;
        // High lane is the upper half of the word
        assign wr_data = lane_err ? ZERO_WORD :
                         {d_s2.hi.data, d_s2.lo.data};
        // Writes run in fill and run, never in flush
        assign wr_valid = link_edge[i] && en_s2[i] && !flush;
        assign rd_ready = read_tick && en_s2[i];

        // Eight word buffer absorbs link latency spread
        ssa_fifo #(
            .W(WORD_W),
            .D(FIFO_DEPTH)
        ) u_fifo (
            .core_clk(core_clk),
            .reset(reset),
            .flush(flush),
            .in_valid(wr_valid),
            .in_ready(wr_ready),
            .in_data(wr_data),
            .out_valid(rd_valid),
            .out_ready(rd_ready),
            .out_data(rd_data)
        );

        // Output word and sticky flags; flush clear wins over set
        always_comb begin
            next_word = out_word[i];
            if (state != SSA_RUN) begin
                next_word = ZERO_WORD;
            end else if (read_tick) begin
                // Missing or disabled stream shows zero
                next_word = (rd_ready && rd_valid) ? rd_data
                                                   : ZERO_WORD;
            end
            next_code_err = (wr_valid && lane_err) ||
                            (code_error[i] && !flush);
            next_align_err = (wr_valid && !wr_ready) ||
                             (rd_ready && !rd_valid) ||
                             (align_error[i] && !flush);
        end

        // Output registers
        always_ff @(posedge core_clk) begin
            if (reset) begin
                out_word[i] <= ZERO_WORD;
                code_error[i] <= 1'b0;
                align_error[i] <= 1'b0;
            end else begin
                out_word[i] <= next_word;
                code_error[i] <= next_code_err;
                align_error[i] <= next_align_err;
            end
        end
    end
endmodule
`default_nettype wire

// ---- hw/ssa_pkg.sv ----
`default_nettype none
// ============================================================
// Shared constants and carriers for the stream aligner
package ssa_pkg;
    // Stream geometry
    localparam int NUM_STREAMS = 16;
    localparam int LANE_W = 16;
    localparam int WORD_W = 32;
    localparam int FIFO_DEPTH = 8;
    // Core clock period in ns
    localparam int CLK_PERIOD_NS = 8;
    // Alignment wait: four link periods of 125 ns in the bench
    localparam int ALIGN_TIME_NS = 500;
    // Least time, rounded up to whole core cycles
    localparam int ALIGN_CYC =
        (ALIGN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ALIGN_CNT_W = 7;
    localparam logic [ALIGN_CNT_W-1:0] ALIGN_LAST =
        ALIGN_CNT_W'(ALIGN_CYC - 1);
    localparam logic [ALIGN_CNT_W-1:0] ALIGN_CNT_RST = 7'h00;
    // Reset and blank values
    localparam logic [WORD_W-1:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [NUM_STREAMS-1:0] FLAGS_RST = 16'h0000;
    localparam logic [2:0] PIPE_RST = 3'h0;

    // One lane: decoded half word and its line coding error
    typedef struct packed {
        logic [LANE_W-1:0] data;
        logic code_err;
    } ssa_lane_t;

    // One source link: high lane and low lane
    typedef struct packed {
        ssa_lane_t hi;
        ssa_lane_t lo;
    } ssa_link_t;

    localparam ssa_link_t LINK_RST = '0;

    // Run alignment states
    typedef enum logic [1:0] {
        SSA_FLUSH = 2'b00,
        SSA_FILL = 2'b01,
        SSA_RUN = 2'b10
    } ssa_state_t;
endpackage
`default_nettype wire

// ---- tb/ssa_align_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Port checker for the stream aligner
module ssa_align_chk (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic run_sync,
    input wire logic [ssa_pkg::NUM_STREAMS-1:0][ssa_pkg::WORD_W-1:0] out_word,
    input wire logic out_valid,
    input wire logic running,
    input wire logic [ssa_pkg::NUM_STREAMS-1:0] code_error,
    input wire logic [ssa_pkg::NUM_STREAMS-1:0] align_error
);
    import ssa_pkg::*;
    logic [7:0] since_sync; // Cycles since sync was last seen high
    logic [7:0] next_since_sync;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // Count up while sync is low, saturating
    always_comb begin
        next_since_sync = since_sync;
        if (run_sync) begin
            next_since_sync = 8'h00;
        end else if (since_sync != 8'hff) begin
            next_since_sync = since_sync + 8'h01;
        end
    end
    // Register the count
    always_ff @(posedge core_clk) begin
        since_sync <= reset ? 8'h00 : next_since_sync;
    end
    a_flush_zero: assert property (
        run_sync [*5] |=> out_word == '0 && !running && !out_valid)
        else $error("outputs not blank in flush");
    a_flags_clear: assert property (
        run_sync [*5] |=> code_error == '0 && align_error == '0)
        else $error("flags not cleared in flush");
    a_fill_quiet: assert property (
        run_sync [*5] ##1 !run_sync |=> (!out_valid && !running) [*8])
        else $error("read during fill");
    a_run_start: assert property (
        $rose(running) |-> since_sync >= ALIGN_CYC + 2 &&
        since_sync <= ALIGN_CYC + 6)
        else $error("readout start off count");
    a_run_bound: assert property (
        since_sync == ALIGN_CYC + 8 |-> running)
        else $error("readout never started");
    a_read_pace: assert property (
        out_valid && running |-> ##[1:17] (out_valid || run_sync))
        else $error("reads stopped");
    a_word_hold: assert property (
        since_sync >= 8 && running && !out_valid |-> $stable(out_word))
        else $error("word changed between reads");
    a_err_sticky: assert property (
        since_sync >= 6 |-> (code_error & $past(code_error)) ==
        $past(code_error))
        else $error("code flag lost");
    c_read: cover property (out_valid && running);
    c_code: cover property (code_error != '0);
    c_align: cover property (align_error != '0);
endmodule
`default_nettype wire

// ---- tb/ssa_align_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self checking bench for the stream aligner
module ssa_align_tb_top;
    import ssa_pkg::*;
    typedef struct packed {
        logic [15:0] en;
        logic [15:0] eh;
        logic [15:0] el;
        logic [15:0] ce; // Expected sticky code flags
    } ssa_row_t;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic run_sync = 1'b1;
    logic [15:0] stream_enable = '0;
    logic [15:0] stall = '0;
    logic [15:0] fast = '0;
    logic [15:0] err_hi = '0;
    logic [15:0] err_lo = '0;
    logic [15:0] seq;
    logic [15:0] link_clk;
    ssa_link_t [15:0] link_in;
    logic [15:0][31:0] out_word;
    logic out_valid;
    logic running;
    logic [15:0] code_error;
    logic [15:0] align_error;
    int error_cnt = 0;
    int num_checks = 0;
    always #4 core_clk = ~core_clk;
    ssa_src_model u_src (.stall, .fast, .err_hi, .err_lo, .seq,
        .link_clk, .link_in);
    ssa_align u_dut (.core_clk, .reset, .run_sync, .stream_enable,
        .link_clk, .link_in, .out_word, .out_valid, .running,
        .code_error, .align_error);
    task automatic results;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: word %h not %h", $time, g, e);
        end
    endtask
    task automatic chk_f(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: flags %h not %h", $time, g, e);
        end
    endtask
    // Wait for a read pulse, bounded
    task automatic wait_v;
        int k;
        k = 0;
        do begin
            @(posedge core_clk);
            #1;
            k++;
        end while (out_valid !== 1'b1 && k < 200);
        if (out_valid !== 1'b1) begin
            error_cnt++;
            $display("wrong value at %0t: no read", $time);
            results();
        end
    endtask
    // Flush, set up, then release sync
    task automatic start_run(input ssa_row_t r);
        @(posedge core_clk);
        run_sync <= 1'b1;
        stream_enable <= r.en;
        err_hi <= r.eh;
        err_lo <= r.el;
        repeat (7) @(posedge core_clk);
        #1;
        chk_f(code_error | align_error, 16'h0000);
        @(posedge core_clk);
        run_sync <= 1'b0;
    endtask
    initial begin
        ssa_row_t rows [4];
        logic [15:0] base;
        rows = '{'{16'hffff, 16'h0000, 16'h0000, 16'h0000},
                 '{16'h00ff, 16'h0000, 16'h0000, 16'h0000},
                 '{16'hffff, 16'h0100, 16'h0002, 16'h0102},
                 '{16'h8001, 16'h0000, 16'h8000, 16'h8000}};
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        chk_f({15'h0, running}, 16'h0000);
        foreach (rows[r]) begin
            start_run(rows[r]);
            wait_v();
            base = out_word[0][15:0];
            chk_f(16'((seq - base) >= 16'h0002), 16'h0001);
            for (int n = 0; n < 3; n++) begin
                if (n > 0) wait_v();
                for (int i = 0; i < 16; i++) begin
                    chk_w(out_word[i], (rows[r].en[i] && !(rows[r].eh[i] |
                        rows[r].el[i])) ? {16'(i), base + 16'(n)} :
                        32'h0);
                end
            end
            chk_f(code_error, rows[r].ce);
            chk_f(align_error, 16'h0000);
            $display("row %0d done", r);
        end
        start_run('{16'hffff, 16'h0000, 16'h0000, 16'h0000});
        wait_v();
        @(posedge core_clk);
        stall <= 16'h0008;
        repeat (6) wait_v();
        chk_f(align_error, 16'h0008);
        @(posedge core_clk);
        stall <= 16'h0000;
        fast <= 16'h0004;
        $display("underflow done");
        start_run('{16'hffff, 16'h0000, 16'h0000, 16'h0000});
        repeat (14) wait_v();
        chk_f(align_error, 16'h0004);
        $display("overflow done");
        @(posedge core_clk);
        reset <= 1'b1;
        fast <= 16'h0000;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        chk_f(align_error | {15'h0, running}, 16'h0000);
        chk_w(out_word[2], 32'h0);
        @(posedge core_clk);
        #1;
        chk_f({14'h0, out_valid, running}, 16'h0000);
        $display("reset done");
        results();
    end
endmodule
bind ssa_align ssa_align_chk u_chk (.core_clk, .reset, .run_sync,
    .out_word, .out_valid, .running, .code_error, .align_error);
`default_nettype wire

// ---- tb/ssa_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Source processors: one word per link period on each lane pair
module ssa_src_model (
    input wire logic [15:0] stall,
    input wire logic [15:0] fast,
    input wire logic [15:0] err_hi,
    input wire logic [15:0] err_lo,
    output var logic [15:0] seq,
    output logic [15:0] link_clk,
    output var ssa_pkg::ssa_link_t [15:0] link_in
);
    import ssa_pkg::*;
    logic slow_clk = 1'b0; // Shared word clock
    logic fast_clk = 1'b0; // Double rate clock to force overflow
    // Stalled links stand still
    assign link_clk = ~stall & ((fast & {16{fast_clk}}) |
        (~fast & {16{slow_clk}}));
    // Free phase against the core clock; one process owns seq and lanes
    initial begin
        seq = 16'h0000;
        link_in = '0;
        #3.3;
        fork
            forever #62.5 slow_clk = ~slow_clk;
            forever #31.25 fast_clk = ~fast_clk;
            // New word mid period, steady around each rising edge
            forever begin
                @(negedge slow_clk);
                seq <= seq + 16'h0001;
                for (int i = 0; i < 16; i++) begin
                    if (stall[i]) begin
                        link_in[i] <= ~link_in[i]; // Idle lanes: junk
                    end else begin
                        link_in[i] <= {16'(i), err_hi[i],
                            seq + 16'h0001, err_lo[i]};
                    end
                end
            end
        join
    end
endmodule
`default_nettype wire
